/* File: verilog/mcs_consts.svh */
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define MCS_ADDR_W 15
`define MCS_BIT_ADDR_W 12
`define MCS_BIT_HI_W 3
`define MCS_FIELD_W 16
`define MCS_STEP_W 4
`define MCS_REP_W 5

// ----------------------------------------
// counts and field positions
// ----------------------------------------
`define MCS_FULL_COUNT 5'h10
`define MCS_HALF_COUNT 5'h08
`define MCS_STORE_HALF_MAX 4'h8
`define MCS_WSREG_CNT_MSB 3
`define MCS_WSREG_CNT_LSB 0
`define MCS_BIT_HI_ZERO 3'h0
`define MCS_CNT_ZERO 4'h0

// ----------------------------------------
// reset values
// ----------------------------------------
`define MCS_STEP_RST 4'h0
`define MCS_REP_RST 5'h00
`define MCS_IDX_RST 4'h0
`define MCS_FIELD_RST 16'h0000
`define MCS_ADDR_RST 15'h0000

`endif

/* File: verilog/mcs_pkg.sv */
package mcs_pkg;

  // machine cycle kinds held in the sequence tables
  typedef enum logic [2:0] {
    MCS_OP_ALU,
    MCS_OP_RD,
    MCS_OP_WR,
    MCS_OP_BITO,
    MCS_OP_BITI,
    MCS_OP_ALUR,
    MCS_OP_END
  } mcs_op_t;

  // sequence phases of one instruction
  typedef enum logic [2:0] {
    MCS_PH_RST,
    MCS_PH_FETCH,
    MCS_PH_SRC,
    MCS_PH_DST,
    MCS_PH_EXEC
  } mcs_phase_t;

  // instruction classes delivered by the opcode decoder
  typedef enum logic [1:0] {
    MCS_CL_GENERIC,
    MCS_CL_SHIFT,
    MCS_CL_LOAD_BITS,
    MCS_CL_STORE_BITS
  } mcs_class_t;

  // cycle timer state
  typedef struct packed {
    logic second;
  } mcs_tmr_t;

  // sequencer state
  typedef struct packed {
    mcs_phase_t ph;
    logic [3:0] step;
    mcs_op_t kind;
    logic [4:0] rep;
    logic [3:0] idx;
    mcs_class_t cls;
    logic [3:0] cnt;
    logic [1:0] smode;
    logic [1:0] dmode;
    logic [14:0] addr;
    logic bout;
    logic [15:0] bitin;
  } mcs_seq_t;

endpackage

/* File: verilog/mcs_cycle_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module mcs_cycle_timer
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // cycle control
  input wire logic wait_req_i,
  // cycle position
  output logic second_o,
  output logic last_o
);

  mcs_tmr_t s_q; // registered timer state
  mcs_tmr_t s_d; // next timer state

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // first clock always moves on; second clock repeats while a wait is asked
  always_comb begin
    s_d = s_q;
    if (!s_q.second) begin
      s_d.second = 1'b1;
    end else if (!wait_req_i) begin
      s_d.second = 1'b0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // cycle ends at the second clock once no wait is asked
  assign second_o = s_q.second;
  assign last_o = s_q.second & ~wait_req_i;

endmodule

`default_nettype wire

/* File: verilog/mcs_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mcs_consts.svh"

module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int ADDR_W = `MCS_ADDR_W,
  parameter int BIT_ADDR_W = `MCS_BIT_ADDR_W
)(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // memory side
  input wire logic ready_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  output logic mem_en_o,
  output logic mem_read_o,
  output logic mem_write_o,
  output logic opcode_fetch_indicator_o,
  output logic [ADDR_W-1:0] addr_o,
  // decoder side, taken at the end of the opcode fetch read
  input wire mcs_class_t dec_class_i,
  input wire logic [3:0] dec_count_i,
  input wire logic [1:0] dec_src_mode_i,
  input wire logic [1:0] dec_dst_mode_i,
  // datapath side
  input wire logic [`MCS_FIELD_W-1:0] workspace_register_zero_i,
  input wire logic [BIT_ADDR_W-1:0] bit_base_i,
  input wire logic [`MCS_FIELD_W-1:0] load_field_i,
  output logic [`MCS_FIELD_W-1:0] store_field_o,
  output logic alu_cycle_o,
  output logic instr_done_o,
  // bit_addressed_io_space side
  input wire logic bit_io_in_i,
  output logic bit_io_out_o,
  output logic bit_io_strobe_o
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // state keeps a fixed fifteen bit address and a twelve bit bit address
  if (ADDR_W != `MCS_ADDR_W || BIT_ADDR_W != `MCS_BIT_ADDR_W ||
      ADDR_W != BIT_ADDR_W + `MCS_BIT_HI_W) begin : g_bad_width
    $error("address widths must stay fifteen and twelve bits");
  end

  // ----------------------------------------
  // sequence tables
  // ----------------------------------------
  // derivation cycles of one addressing mode
  function automatic mcs_op_t mode_op(input logic [1:0] mode, input logic [3:0] s);
    mcs_op_t op;
    op = MCS_OP_END;
    unique case (mode)
      2'h0: op = MCS_OP_END; // register direct, no extra cycles
      2'h1: op = (s == 4'h0) ? MCS_OP_RD : (s == 4'h1) ? MCS_OP_ALU : MCS_OP_END;
      2'h2: op = (s == 4'h1) ? MCS_OP_RD : (s < 4'h3) ? MCS_OP_ALU : MCS_OP_END;
      2'h3: op = (s == 4'h0) ? MCS_OP_RD : (s == 4'h1) ? MCS_OP_ALU :
                 (s == 4'h2) ? MCS_OP_WR : MCS_OP_END;
    endcase
    return op;
  endfunction

  // cycle kind at a step of a phase
  function automatic mcs_op_t op_at(input mcs_phase_t ph, input mcs_class_t cls,
                                    input logic czero, input logic [1:0] sm,
                                    input logic [1:0] dm, input logic [3:0] s);
    mcs_op_t op;
    op = MCS_OP_END;
    unique case (ph)
      MCS_PH_RST: begin
        case (s)
          4'h2, 4'h9: op = MCS_OP_RD;
          4'h4, 4'h6, 4'h8: op = MCS_OP_WR;
          4'hB: op = MCS_OP_END;
          default: op = MCS_OP_ALU;
        endcase
      end
      MCS_PH_FETCH: begin
        op = (s == 4'h0) ? MCS_OP_RD : (s == 4'h1) ? MCS_OP_ALU : MCS_OP_END;
      end
      MCS_PH_SRC: begin
        op = (cls == MCS_CL_SHIFT) ? MCS_OP_END : mode_op(sm, s);
      end
      MCS_PH_DST: begin
        op = (cls == MCS_CL_GENERIC) ? mode_op(dm, s) : MCS_OP_END;
      end
      MCS_PH_EXEC: begin
        unique case (cls)
          MCS_CL_GENERIC: begin
            op = (s == 4'h0) ? MCS_OP_RD : (s == 4'h1) ? MCS_OP_ALU :
                 (s == 4'h2) ? MCS_OP_WR : MCS_OP_END;
          end
          MCS_CL_SHIFT: begin
            if (!czero) begin
              case (s)
                4'h0: op = MCS_OP_RD;
                4'h1: op = MCS_OP_ALU;
                4'h2: op = MCS_OP_ALUR;
                4'h3: op = MCS_OP_WR;
                4'h4: op = MCS_OP_ALU;
                default: op = MCS_OP_END;
              endcase
            end else begin
              case (s)
                4'h0, 4'h3: op = MCS_OP_RD;
                4'h6: op = MCS_OP_ALUR;
                4'h8: op = MCS_OP_END;
                default: op = (s > 4'h8) ? MCS_OP_END : MCS_OP_ALU;
              endcase
            end
          end
          MCS_CL_LOAD_BITS: begin
            case (s)
              4'h0, 4'h3: op = MCS_OP_RD;
              4'h5: op = MCS_OP_BITO;
              4'h7: op = MCS_OP_END;
              default: op = (s > 4'h7) ? MCS_OP_END : MCS_OP_ALU;
            endcase
          end
          MCS_CL_STORE_BITS: begin
            case (s)
              4'h0, 4'h3: op = MCS_OP_RD;
              4'h5: op = MCS_OP_BITI;
              4'hA: op = MCS_OP_WR;
              4'hB: op = MCS_OP_END;
              default: op = (s > 4'hB) ? MCS_OP_END : MCS_OP_ALU;
            endcase
          end
        endcase
      end
      default: op = MCS_OP_END;
    endcase
    return op;
  endfunction

  // phase that follows a finished one
  function automatic mcs_phase_t next_ph(input mcs_phase_t ph);
    mcs_phase_t n;
    n = MCS_PH_FETCH;
    unique case (ph)
      MCS_PH_FETCH: n = MCS_PH_SRC;
      MCS_PH_SRC: n = MCS_PH_DST;
      MCS_PH_DST: n = MCS_PH_EXEC;
      default: n = MCS_PH_FETCH;
    endcase
    return n;
  endfunction

  // number of repeated cycles for the repeat step of a class
  function automatic logic [4:0] rep_count(input mcs_class_t cls, input logic [3:0] c,
                                           input logic [3:0] wsreg);
    logic [4:0] n;
    n = `MCS_FULL_COUNT;
    unique case (cls)
      MCS_CL_LOAD_BITS: n = (c == `MCS_CNT_ZERO) ? `MCS_FULL_COUNT : {1'b0, c};
      MCS_CL_STORE_BITS: n = (c == `MCS_CNT_ZERO || c > `MCS_STORE_HALF_MAX) ?
                             `MCS_FULL_COUNT : `MCS_HALF_COUNT;
      MCS_CL_SHIFT: begin
        if (c != `MCS_CNT_ZERO) begin
          n = {1'b0, c};
        end else begin
          n = (wsreg == `MCS_CNT_ZERO) ? `MCS_FULL_COUNT : {1'b0, wsreg};
        end
      end
      default: n = `MCS_FULL_COUNT;
    endcase
    return n;
  endfunction

  // repeated cycle kinds
  function automatic logic is_rep(input mcs_op_t op);
    return op == MCS_OP_ALUR || op == MCS_OP_BITO || op == MCS_OP_BITI;
  endfunction

  // ----------------------------------------
  // state and cycle timer
  // ----------------------------------------
  mcs_seq_t s_q; // registered sequencer state
  mcs_seq_t s_d; // next sequencer state
  logic mem_cycle; // current cycle uses the memory bus
  logic second; // second clock of the cycle
  logic last; // final clock of the cycle
  logic [3:0] wsreg_cnt; // shift count nibble of workspace_register_zero

  assign mem_cycle = (s_q.kind == MCS_OP_RD) || (s_q.kind == MCS_OP_WR);
  assign wsreg_cnt = workspace_register_zero_i[`MCS_WSREG_CNT_MSB:`MCS_WSREG_CNT_LSB];

  // two clocks per cycle, memory cycles stretched by ready
  mcs_cycle_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .srst_i (srst_i),
    .wait_req_i (mem_cycle & ~ready_i),
    .second_o (second),
    .last_o (last)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    mcs_op_t op;
    mcs_phase_t ph;
    logic [3:0] st;
    s_d = s_q;
    op = MCS_OP_END;
    ph = s_q.ph;
    st = s_q.step;
    if (last) begin
      // input bit captured at the end of the second clock
      if (s_q.kind == MCS_OP_BITI) begin
        s_d.bitin[s_q.idx] = bit_io_in_i;
      end
      // decoder fields taken when the opcode read completes
      if (s_q.ph == MCS_PH_FETCH && s_q.kind == MCS_OP_RD) begin
        s_d.cls = dec_class_i;
        s_d.cnt = dec_count_i;
        s_d.smode = dec_src_mode_i;
        s_d.dmode = dec_dst_mode_i;
      end
      if (is_rep(s_q.kind) && s_q.rep > 5'h01) begin
        // another cycle of the same repeated kind
        s_d.rep = s_q.rep - 5'h01;
        s_d.idx = s_q.idx + 4'h1;
        op = s_q.kind;
      end else begin
        // walk past finished and empty phases
        st = s_q.step + 4'h1;
        op = op_at(ph, s_d.cls, s_d.cnt == `MCS_CNT_ZERO, s_d.smode, s_d.dmode, st);
        for (int i = 0; i < 4; i++) begin
          if (op == MCS_OP_END) begin
            ph = next_ph(ph);
            st = `MCS_STEP_RST;
            op = op_at(ph, s_d.cls, s_d.cnt == `MCS_CNT_ZERO, s_d.smode, s_d.dmode, st);
          end
        end
        if (is_rep(op)) begin
          s_d.rep = rep_count(s_d.cls, s_d.cnt, wsreg_cnt);
          s_d.idx = `MCS_IDX_RST;
        end
      end
      s_d.ph = ph;
      s_d.step = st;
      s_d.kind = op;
      // address and output bit set up for the new cycle; ALU leaves them
      if (op == MCS_OP_RD || op == MCS_OP_WR) begin
        s_d.addr = mem_addr_i;
      end else if (op == MCS_OP_BITO || op == MCS_OP_BITI) begin
        s_d.addr = {`MCS_BIT_HI_ZERO, bit_base_i + {{(BIT_ADDR_W-4){1'b0}}, s_d.idx}};
        if (op == MCS_OP_BITO) begin
          s_d.bout = load_field_i[s_d.idx];
        end
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // reset restarts the context switch and drops any cycle in flight
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_q.ph <= MCS_PH_RST;
      s_q.step <= `MCS_STEP_RST;
      s_q.kind <= MCS_OP_ALU;
      s_q.rep <= `MCS_REP_RST;
      s_q.idx <= `MCS_IDX_RST;
      s_q.cls <= MCS_CL_GENERIC;
      s_q.cnt <= `MCS_CNT_ZERO;
      s_q.smode <= 2'h0;
      s_q.dmode <= 2'h0;
      s_q.addr <= `MCS_ADDR_RST;
      s_q.bout <= 1'b0;
      s_q.bitin <= `MCS_FIELD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign mem_en_o = mem_cycle;
  assign mem_read_o = s_q.kind == MCS_OP_RD;
  assign mem_write_o = (s_q.kind == MCS_OP_WR) & second;
  assign opcode_fetch_indicator_o = (s_q.ph == MCS_PH_FETCH) & (s_q.kind == MCS_OP_RD);
  assign addr_o = s_q.addr;
  assign bit_io_out_o = s_q.bout;
  assign bit_io_strobe_o = (s_q.kind == MCS_OP_BITO) & second;
  assign store_field_o = s_q.bitin;
  assign alu_cycle_o = (s_q.kind == MCS_OP_ALU) | (s_q.kind == MCS_OP_ALUR);
  assign instr_done_o = last & (s_q.ph == MCS_PH_EXEC) &
                        (op_at(MCS_PH_EXEC, s_q.cls, s_q.cnt == `MCS_CNT_ZERO, s_q.smode, s_q.dmode,
                               s_q.step + 4'h1) == MCS_OP_END) &
                        ~(is_rep(s_q.kind) && s_q.rep > 5'h01);

endmodule

`default_nettype wire

/* File: verif/mcs_sequencer_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module mcs_sequencer_checker #(
  parameter int ADDR_W = 15,
  parameter int BIT_ADDR_W = 12
)(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // memory side
  input wire logic ready_i,
  input wire logic mem_en_o,
  input wire logic mem_read_o,
  input wire logic mem_write_o,
  input wire logic opcode_fetch_indicator_o,
  input wire logic [ADDR_W-1:0] addr_o,
  // cycle reporting
  input wire logic alu_cycle_o,
  input wire logic instr_done_o,
  // bit side
  input wire logic bit_io_out_o,
  input wire logic bit_io_strobe_o
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic in_second_q; // memory cycle is past its first clock
  logic [4:0] alu_run_q; // consecutive alu clocks seen

  // track memory cycle position and alu run length
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      in_second_q <= 1'b0;
      alu_run_q <= 5'h00;
    end else begin
      in_second_q <= mem_en_o && !(in_second_q && ready_i);
      alu_run_q <= alu_cycle_o ? alu_run_q + 5'h01 : 5'h00;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_FETCH_READ: assert property (opcode_fetch_indicator_o |-> mem_en_o && mem_read_o && !mem_write_o)
    else $error("fetch indicator outside a read");
  AST_ALU_QUIET: assert property (alu_cycle_o |-> !mem_en_o && !mem_write_o && !bit_io_strobe_o)
    else $error("controls active in alu cycle");
  AST_ALU_TWO: assert property ($fell(alu_cycle_o) |-> !alu_run_q[0])
    else $error("odd alu clock count");
  AST_WR_SECOND: assert property (mem_write_o |-> in_second_q && mem_en_o && !mem_read_o)
    else $error("write strobe in first clock");
  AST_MEM_TWO: assert property (mem_en_o && !in_second_q |=> mem_en_o && $stable(addr_o))
    else $error("memory cycle shorter than two clocks");
  AST_WAIT_HOLD: assert property (mem_en_o && in_second_q && !ready_i |=> mem_en_o && $stable(addr_o) && $stable(mem_read_o))
    else $error("wait clock not inserted");
  AST_BIT_ADDR: assert property (!mem_en_o && !alu_cycle_o |-> addr_o[ADDR_W-1 -: 3] == 3'h0)
    else $error("upper address lines not low");
  AST_STROBE_SECOND: assert property (bit_io_strobe_o |-> !$past(mem_en_o) && !$past(alu_cycle_o) && !$past(bit_io_strobe_o) && $stable(addr_o) && $stable(bit_io_out_o))
    else $error("bit strobe not in second clock");
  AST_DONE_FETCH: assert property (instr_done_o |=> opcode_fetch_indicator_o && !instr_done_o)
    else $error("no fetch after done");
  AST_RESET_SEQ: assert property ($fell(srst_i) |-> alu_cycle_o [*4] ##1 (mem_en_o && mem_read_o && !opcode_fetch_indicator_o))
    else $error("reset sequence start wrong");

  // main scenarios reached
  COV_STROBE: cover property (bit_io_strobe_o);
  COV_WAIT: cover property (mem_en_o && in_second_q && !ready_i);
  COV_DONE: cover property (instr_done_o);
endmodule

bind mcs_sequencer mcs_sequencer_checker #(.ADDR_W(ADDR_W), .BIT_ADDR_W(BIT_ADDR_W)) u_checker (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ready_i(ready_i), .mem_en_o(mem_en_o),
  .mem_read_o(mem_read_o), .mem_write_o(mem_write_o), .opcode_fetch_indicator_o(opcode_fetch_indicator_o),
  .addr_o(addr_o), .alu_cycle_o(alu_cycle_o), .instr_done_o(instr_done_o),
  .bit_io_out_o(bit_io_out_o), .bit_io_strobe_o(bit_io_strobe_o));
`default_nettype wire

/* File: verif/mcs_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none

module mcs_mem_model (
  // clock
  input wire logic ref_clk_i,
  // sequencer outputs
  input wire logic mem_en_i,
  input wire logic alu_cycle_i,
  input wire logic [14:0] addr_i,
  // answers
  output logic ready_o,
  output logic bit_io_in_o
);
  logic filler_q = 1'b0; // changes every clock while no bit is selected

  // random wait states, drawn fresh each clock
  always @(posedge ref_clk_i) begin
    ready_o <= ($urandom_range(2) != 0);
    filler_q <= ~filler_q;
  end

  // selected input bit is a fixed mix of the bit address
  assign bit_io_in_o = (!mem_en_i && !alu_cycle_i) ? (addr_i[0] ^ addr_i[3] ^ addr_i[7]) : filler_q;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
  import mcs_pkg::*;
  // ----------------------------------------
  // stimulus, outputs, bookkeeping
  // ----------------------------------------
  logic ref_clk_i = 1'b0, srst_i = 1'b1, ready_i, bit_io_in_i, fetch_ind, prev_fetch = 1'b0, after_rst = 1'b1;
  logic [14:0] mem_addr_i = 15'h0000, addr_o;
  mcs_class_t dec_class_i = MCS_CL_GENERIC, run_cls;
  logic [3:0] dec_count_i = 4'h0, run_cnt, run_nib;
  logic [1:0] dec_src_mode_i = 2'h0, dec_dst_mode_i = 2'h0, run_sm, run_dm;
  logic [15:0] wsreg_zero = 16'h0000, load_field_i = 16'h0000, store_field_o, run_load;
  logic [11:0] bit_base_i = 12'h000, run_base;
  logic mem_en_o, mem_read_o, mem_write_o, alu_cycle_o, instr_done_o, bit_io_out_o, bit_io_strobe_o, mpos = 1'b0;
  int error_cnt = 0, total_checks = 0, cyc = 0, n_instr = 0, pick = 0, rst_hold = 20;
  int alu_clk = 0, mem_cyc = 0, bit_clk = 0, strb = 0, dones = 0;
  // corner cases: {class, count, shift nibble, src mode, dst mode}
  localparam logic [13:0] DIRECTED [16] = '{14'h2004, 14'h2108, 14'h2F0C, 14'h3000, 14'h3104, 14'h3800,
    14'h3908, 14'h3F0C, 14'h1000, 14'h1050, 14'h110C, 14'h1F00, 14'h0001, 14'h0006, 14'h000B, 14'h000C};

  always #2.5 ref_clk_i = ~ref_clk_i;

  mcs_mem_model u_mem (.ref_clk_i(ref_clk_i), .mem_en_i(mem_en_o), .alu_cycle_i(alu_cycle_o),
    .addr_i(addr_o), .ready_o(ready_i), .bit_io_in_o(bit_io_in_i));

  mcs_sequencer dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ready_i(ready_i), .mem_addr_i(mem_addr_i),
    .mem_en_o(mem_en_o), .mem_read_o(mem_read_o), .mem_write_o(mem_write_o),
    .opcode_fetch_indicator_o(fetch_ind), .addr_o(addr_o), .dec_class_i(dec_class_i),
    .dec_count_i(dec_count_i), .dec_src_mode_i(dec_src_mode_i), .dec_dst_mode_i(dec_dst_mode_i),
    .workspace_register_zero_i(wsreg_zero), .bit_base_i(bit_base_i), .load_field_i(load_field_i),
    .store_field_o(store_field_o), .alu_cycle_o(alu_cycle_o), .instr_done_o(instr_done_o),
    .bit_io_in_i(bit_io_in_i), .bit_io_out_o(bit_io_out_o), .bit_io_strobe_o(bit_io_strobe_o));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // bit that the far side returns for a bit address
  function automatic logic in_bit(input logic [11:0] a);
    return a[0] ^ a[3] ^ a[7];
  endfunction

  // expected {memory cycles, alu cycles, bit cycles} of one instruction
  function automatic logic [23:0] expect_cnt(input mcs_class_t c, input logic [3:0] n,
      input logic [1:0] sm, input logic [1:0] dm, input logic [3:0] nib);
    logic [7:0] m, a, b;
    m = 8'h03;
    a = 8'h01;
    b = 8'h00;
    if (c != MCS_CL_SHIFT) begin
      m += (sm == 2'h3) ? 8'h02 : {7'h00, sm != 2'h0};
      a += (sm == 2'h2) ? 8'h02 : {7'h00, sm != 2'h0};
    end
    if (c == MCS_CL_GENERIC) begin
      m += (dm == 2'h3) ? 8'h02 : {7'h00, dm != 2'h0};
      a += (dm == 2'h2) ? 8'h02 : {7'h00, dm != 2'h0};
    end
    case (c)
      MCS_CL_GENERIC: a += 8'h01;
      MCS_CL_SHIFT: a += (n != 4'h0) ? 8'h02 + n : (nib == 4'h0) ? 8'h15 : 8'h05 + nib;
      MCS_CL_LOAD_BITS: begin
        a += 8'h04;
        b = (n == 4'h0) ? 8'h10 : {4'h0, n};
      end
      default: begin
        m += 8'h01;
        a += 8'h07;
        b = (n == 4'h0 || n > 4'h8) ? 8'h10 : 8'h08;
      end
    endcase
    return {m, a, b};
  endfunction

  // next instruction, directed first then random
  task automatic next_instr();
    logic [31:0] w, r;
    w = (pick < 16) ? {18'h00000, DIRECTED[pick]} : $urandom;
    r = $urandom;
    pick++;
    dec_class_i <= mcs_class_t'(w[13:12]);
    dec_count_i <= w[11:8];
    wsreg_zero <= {r[11:0], w[7:4]};
    dec_src_mode_i <= w[3:2];
    dec_dst_mode_i <= w[1:0];
    load_field_i <= r[31:16];
    bit_base_i <= r[27:16];
    mem_addr_i <= r[26:12];
  endtask

  // compare the finished segment, then start the next one
  task automatic end_segment();
    logic [23:0] e;
    e = expect_cnt(run_cls, run_cnt, run_sm, run_dm, run_nib);
    if (after_rst) begin
      check(alu_clk, 12);
      check(mem_cyc, 5);
      check(dones, 0);
    end else begin
      check(mem_cyc, e[23:16]);
      check(alu_clk, {e[15:8], 1'b0});
      check(bit_clk, {e[7:0], 1'b0});
      check(strb, (run_cls == MCS_CL_LOAD_BITS) ? e[7:0] : 8'h00);
      check(dones, 1);
      for (int i = 0; i < e[7:0] && run_cls == MCS_CL_STORE_BITS; i++) check(store_field_o[i], in_bit(run_base + 12'(i)));
      n_instr++;
    end
    after_rst = 1'b0;
    run_cls = dec_class_i;
    {run_cnt, run_nib, run_sm, run_dm} = {dec_count_i, wsreg_zero[3:0], dec_src_mode_i, dec_dst_mode_i};
    {run_load, run_base} = {load_field_i, bit_base_i};
    {alu_clk, mem_cyc, bit_clk, strb, dones} = {5{32'sd0}};
  endtask

  // ----------------------------------------
  // monitor, reset and instruction feed
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (fetch_ind && !prev_fetch) end_segment();
    prev_fetch = fetch_ind;
    if (srst_i) begin
      {after_rst, prev_fetch, mpos} = 3'b100;
    end else begin
      alu_clk += alu_cycle_o;
      bit_clk += (!mem_en_o && !alu_cycle_o);
      dones += instr_done_o;
      if (bit_io_strobe_o) begin
        check(bit_io_out_o, run_load[strb]);
        check(addr_o, {3'h0, run_base + 12'(strb)});
        strb++;
      end
      if (!mem_en_o) mpos = 1'b0;
      else if (!mpos) mpos = 1'b1;
      else if (ready_i) {mpos, mem_cyc} = {1'b0, mem_cyc + 1};
      if (instr_done_o) begin
        next_instr();
        if (pick == 24) begin
          srst_i <= 1'b1; // aligned with the fetch first clock
          rst_hold = 4;
        end
      end
    end
    if (rst_hold > 0) begin
      rst_hold--;
      if (rst_hold == 0) srst_i <= 1'b0;
    end
  end

  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(29));
    next_instr();
    wait (n_instr == 60);
    give_verdict();
  end
endmodule
`default_nettype wire
